// ### shared/adcsq_regs.vh
// Constants for the ADC sample sequencer control block.
// Assumes a 100 MHz system clock from which the ADC step rate is divided.
`ifndef ADCSQ_REGS_VH
`define ADCSQ_REGS_VH

// Clock figures
`define ADCSQ_SYS_CLK_HZ 100000000
`define ADCSQ_ADC_CLK_HZ 16667000
`define ADCSQ_ADC_DIV ((`ADCSQ_SYS_CLK_HZ + `ADCSQ_ADC_CLK_HZ / 2) / `ADCSQ_ADC_CLK_HZ)

// Step control nibble fields
`define ADCSQ_CTL_DIFF 0
`define ADCSQ_CTL_END 1
`define ADCSQ_CTL_IE 2
`define ADCSQ_CTL_TEMP 3

// Per-sequencer status word fields (16 bits per sequencer)
`define ADCSQ_ST_TAIL_LSB 0
`define ADCSQ_ST_HEAD_LSB 4
`define ADCSQ_ST_EMPTY 8
`define ADCSQ_ST_FULL 12
`define ADCSQ_ST_RESET 16'h0100

// Sequencer capacities and FIFO depths
`define ADCSQ_CAP0 8
`define ADCSQ_CAP1 4
`define ADCSQ_CAP2 4
`define ADCSQ_CAP3 1

// Trigger source codes
`define ADCSQ_TRIG_SW 4'h0
`define ADCSQ_TRIG_EXT0 4'h1
`define ADCSQ_TRIG_EXT3 4'h4
`define ADCSQ_TRIG_ALWAYS 4'hf

// Averaging
`define ADCSQ_AVG_OFF 3'h0
`define ADCSQ_AVG_MAX 3'h6

`endif

// ### src/adcsq_top.v
// ADC sample sequencer control: four sequencers, arbitration, averaging,
// result FIFOs, interrupts and FIFO error flags.
// Assumes the converter core runs on CLK_IN and pulses CONV_DONE_IN once.
// What this block does
// - Four sequencers of eight, four, four and one steps, matching FIFO depths
// - Each FIFO word is 32 bits, result in low 10 bits
// - Each step has a 4-bit input nibble and a 4-bit control nibble
// - A sequencer runs only while enabled; program steps before enabling
// - Steps with interrupt enable raise the raw interrupt on completion
// - Sequence stops after the step carrying the end bit
// - Each result FIFO is circular; each read pops the oldest entry
// - Head, tail, full and empty of each FIFO are readable
// - Overflow and underflow are recorded per sequencer
// - Control steps at about 16.667 MHz, divided from the system clock
// - Raw interrupt reaches the controller only when its mask bit is set
// - Raw status and masked status are both visible
// - Writing one to masked status clears that interrupt; zero does nothing
// - Concurrent triggers served by priority value, zero most urgent
// - Each sequencer picks its trigger; software and always are offered
// - Initiate bit starts a sequencer set for the software trigger
// - Averaging folds up to 64 conversions into one FIFO entry
// - Averaging off after reset; one setting shared by all channels
// - Single-ended codes run 0x000 to 0x3ff as delivered by the core
// - Differential pair k samples input 2k positive, 2k+1 negative
// - Differential zero gives 0x1ff, codes pass through unchanged
`timescale 1ns/100ps
`default_nettype none
`include "adcsq_regs.vh"

module adcsq_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk_in,
	input wire rst_in,
	input wire in_valid_in,
	input wire [WIDTH-1:0] in_data_in,
	output wire in_ready_out,
	input wire out_ready_in,
	output wire out_valid_out,
	output wire [WIDTH-1:0] out_data_out,
	output wire [AW-1:0] head_out,
	output wire [AW-1:0] tail_out,
	output wire full_out,
	output wire empty_out
);
	localparam integer LAST_I = DEPTH - 1;
	localparam [AW:0] FULL_CNT = DEPTH[AW:0];
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] rd_q;
	reg [AW-1:0] wr_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;

	assign full_out = (cnt_q == FULL_CNT);
	assign empty_out = (cnt_q == {(AW+1){1'b0}});
	assign in_ready_out = ~full_out;
	assign out_valid_out = ~empty_out;
	assign push = in_valid_in & in_ready_out;
	assign pop = out_ready_in & out_valid_out;
	assign out_data_out = mem[rd_q];
	assign head_out = rd_q;
	assign tail_out = wr_q;

	// Pointers wrap at the depth, so any depth works, not just powers of two
	always @(posedge clk_in) begin
		if (rst_in) begin
			rd_q <= {AW{1'b0}};
			wr_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				mem[wr_q] <= in_data_in;
				wr_q <= (wr_q == LAST_I[AW-1:0]) ? {AW{1'b0}} : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == LAST_I[AW-1:0]) ? {AW{1'b0}} : rd_q + 1'b1;
			end
			if (push & ~pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop & ~push) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule // adcsq_fifo

module adcsq_top (
	input wire CLK_IN,
	input wire SYS_RST_IN,
	input wire [3:0] SEQ_ENABLE_IN,
	input wire [7:0] SEQ_PRIORITY_IN,
	input wire [15:0] TRIG_EVENT_SELECT_IN,
	input wire [3:0] SW_INITIATE_IN,
	input wire [3:0] EXT_TRIG_IN,
	input wire [127:0] STEP_INPUT_SELECT_IN,
	input wire [127:0] STEP_CONTROL_IN,
	input wire [2:0] AVG_CONTROL_IN,
	input wire [3:0] INT_MASK_IN,
	input wire [3:0] INT_CLEAR_IN,
	input wire [3:0] OVF_CLEAR_IN,
	input wire [3:0] UNF_CLEAR_IN,
	input wire [3:0] FIFO_READ_IN,
	input wire CONV_DONE_IN,
	input wire [9:0] CONV_RESULT_IN,
	output reg CONV_START_OUT,
	output reg [3:0] CONV_INPUT_OUT,
	output reg [3:0] CONV_NEG_INPUT_OUT,
	output reg CONV_DIFF_OUT,
	output reg CONV_TEMP_OUT,
	output wire [3:0] RAW_INT_STATUS_OUT,
	output wire [3:0] MASKED_INT_STATUS_OUT,
	output wire [3:0] SEQ_INT_OUT,
	output wire [3:0] OVF_STATUS_OUT,
	output wire [3:0] UNF_STATUS_OUT,
	output reg [63:0] FIFO_STATUS_OUT,
	output reg [31:0] FIFO_DATA_OUT,
	output reg FIFO_DATA_VALID_OUT,
	output wire BUSY_OUT
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_START = 3'b010;
	localparam [2:0] ST_WAIT = 3'b100;
	localparam integer DIV_LAST = `ADCSQ_ADC_DIV - 1;
	localparam integer LAST0 = `ADCSQ_CAP0 - 1, LAST1 = `ADCSQ_CAP1 - 1;
	localparam integer LAST2 = `ADCSQ_CAP2 - 1, LAST3 = `ADCSQ_CAP3 - 1;

	reg [2:0] state_q;
	reg [3:0] div_q;
	reg adc_tick_q;
	reg [3:0] pend_q;
	reg [1:0] cur_q;
	reg [2:0] step_q;
	reg [15:0] acc_q;
	reg [6:0] avg_cnt_q;
	reg [3:0] raw_q, ovf_q, unf_q;
	reg push_v_q;
	reg [1:0] push_sel_q;
	reg [31:0] push_data_q;
	reg [3:0] ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q;
	reg [3:0] trig, seq_done, int_set, tsel;
	reg grant_any;
	reg [1:0] grant_sel;
	reg [2:0] last_step;
	integer p, s, t;

	wire [3:0] sel_nib, ctl_nib, pend_d;
	wire [2:0] avg_n;
	wire [6:0] avg_target;
	wire [15:0] acc_next;
	wire [9:0] avg_result;
	wire avg_full, step_end;
	wire [3:0] ext_rise, fifo_full, fifo_empty, fifo_in_ready;
	wire [127:0] fifo_data;
	wire [63:0] fifo_status;

	// System clock divided to the ADC control rate
	always @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			div_q <= 4'h0;
			adc_tick_q <= 1'b0;
		end else begin
			adc_tick_q <= (div_q == DIV_LAST[3:0]);
			div_q <= (div_q == DIV_LAST[3:0]) ? 4'h0 : div_q + 4'h1;
		end
	end

	// Pin triggers: three stages; the level moves only once stages two and three agree
	always @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			ext_s1_q <= 4'h0;
			ext_s2_q <= 4'h0;
			ext_s3_q <= 4'h0;
			ext_lvl_q <= 4'h0;
		end else begin
			ext_s1_q <= EXT_TRIG_IN;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			ext_lvl_q <= (ext_s2_q & ext_s3_q) | (ext_lvl_q & (ext_s2_q | ext_s3_q));
		end
	end
	assign ext_rise = ext_s2_q & ext_s3_q & ~ext_lvl_q;
	// Per-sequencer trigger multiplexer
	always @* begin
		trig = 4'h0;
		for (t = 0; t < 4; t = t + 1) begin
			tsel = TRIG_EVENT_SELECT_IN[t*4 +: 4];
			if (tsel == `ADCSQ_TRIG_SW) begin
				trig[t] = SW_INITIATE_IN[t];
			end else if (tsel == `ADCSQ_TRIG_ALWAYS) begin
				trig[t] = 1'b1;
			end else if (tsel >= `ADCSQ_TRIG_EXT0 && tsel <= `ADCSQ_TRIG_EXT3) begin
				trig[t] = ext_rise[tsel[1:0] - 2'd1];
			end
		end
	end
	// Fixed-priority pick among pending sequencers; equal values favour lower index
	always @* begin
		grant_any = 1'b0;
		grant_sel = 2'd0;
		for (p = 3; p >= 0; p = p - 1) begin
			for (s = 3; s >= 0; s = s - 1) begin
				if (pend_q[s] && SEQ_PRIORITY_IN[s*2 +: 2] == p[1:0]) begin
					grant_any = 1'b1;
					grant_sel = s[1:0];
				end
			end
		end
	end

	// Step fields addressed as sequencer*32 + step*4
	assign sel_nib = STEP_INPUT_SELECT_IN[{cur_q, step_q, 2'b00} +: 4];
	assign ctl_nib = STEP_CONTROL_IN[{cur_q, step_q, 2'b00} +: 4];

	always @* begin
		case (cur_q)
			2'd0: last_step = LAST0[2:0];
			2'd1: last_step = LAST1[2:0];
			2'd2: last_step = LAST2[2:0];
			default: last_step = LAST3[2:0];
		endcase
	end
	assign step_end = ctl_nib[`ADCSQ_CTL_END] | (step_q == last_step);

	// Averaging: 2^n conversions, n clipped at 6 so at most 64
	assign avg_n = (AVG_CONTROL_IN > `ADCSQ_AVG_MAX) ? `ADCSQ_AVG_MAX : AVG_CONTROL_IN;
	assign avg_target = 7'h01 << avg_n;
	assign acc_next = acc_q + {6'h00, CONV_RESULT_IN};
	assign avg_full = (avg_cnt_q + 7'h01 == avg_target);
	assign avg_result = acc_next[avg_n +: 10];

	// Completion events of the current step
	always @* begin
		seq_done = 4'h0;
		int_set = 4'h0;
		if (state_q == ST_WAIT && CONV_DONE_IN && avg_full) begin
			int_set[cur_q] = ctl_nib[`ADCSQ_CTL_IE];
			seq_done[cur_q] = step_end | ~SEQ_ENABLE_IN[cur_q];
		end
	end
	// A new trigger in the finishing cycle keeps the sequencer pending
	assign pend_d = ((pend_q & ~seq_done) | trig) & SEQ_ENABLE_IN;

	always @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			state_q <= ST_IDLE;
			pend_q <= 4'h0;
			cur_q <= 2'd0;
			step_q <= 3'd0;
			acc_q <= 16'h0000;
			avg_cnt_q <= 7'h00;
			push_v_q <= 1'b0;
			push_sel_q <= 2'd0;
			push_data_q <= 32'h00000000;
			CONV_START_OUT <= 1'b0;
			CONV_INPUT_OUT <= 4'h0;
			CONV_NEG_INPUT_OUT <= 4'h0;
			CONV_DIFF_OUT <= 1'b0;
			CONV_TEMP_OUT <= 1'b0;
		end else begin
			pend_q <= pend_d;
			push_v_q <= 1'b0;
			CONV_START_OUT <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (adc_tick_q && grant_any) begin
						cur_q <= grant_sel;
						step_q <= 3'd0;
						acc_q <= 16'h0000;
						avg_cnt_q <= 7'h00;
						state_q <= ST_START;
					end
				end
				ST_START: begin
					if (adc_tick_q) begin
						CONV_START_OUT <= 1'b1;
						CONV_DIFF_OUT <= ctl_nib[`ADCSQ_CTL_DIFF];
						CONV_TEMP_OUT <= ctl_nib[`ADCSQ_CTL_TEMP];
						if (ctl_nib[`ADCSQ_CTL_DIFF]) begin
							CONV_INPUT_OUT <= {1'b0, sel_nib[1:0], 1'b0};
							CONV_NEG_INPUT_OUT <= {1'b0, sel_nib[1:0], 1'b1};
						end else begin
							CONV_INPUT_OUT <= sel_nib;
							CONV_NEG_INPUT_OUT <= 4'h0;
						end
						state_q <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (CONV_DONE_IN) begin
						if (avg_full) begin
							// Core codes pass through untouched in both modes
							push_v_q <= 1'b1;
							push_sel_q <= cur_q;
							push_data_q <= {22'h000000, avg_result};
							acc_q <= 16'h0000;
							avg_cnt_q <= 7'h00;
							if (seq_done[cur_q]) begin
								state_q <= ST_IDLE;
							end else begin
								step_q <= step_q + 3'd1;
								state_q <= ST_START;
							end
						end else begin
							// Same step repeats; throughput drops by the average count
							acc_q <= acc_next;
							avg_cnt_q <= avg_cnt_q + 7'h01;
							state_q <= ST_START;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
	assign BUSY_OUT = (state_q != ST_IDLE);

	// Result FIFOs, one per sequencer, sized by capacity
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_fifo
			localparam DEP = (g == 0) ? `ADCSQ_CAP0 : (g == 1) ? `ADCSQ_CAP1 :
				(g == 2) ? `ADCSQ_CAP2 : `ADCSQ_CAP3;
			localparam AW = (DEP > 4) ? 3 : (DEP > 2) ? 2 : 1;
			wire [AW-1:0] head;
			wire [AW-1:0] tail;
			adcsq_fifo #(.WIDTH(32), .DEPTH(DEP), .AW(AW)) u_fifo (
				.clk_in(CLK_IN),
				.rst_in(SYS_RST_IN),
				.in_valid_in(push_v_q && push_sel_q == g),
				.in_data_in(push_data_q),
				.in_ready_out(fifo_in_ready[g]),
				.out_ready_in(FIFO_READ_IN[g]),
				.out_valid_out(),
				.out_data_out(fifo_data[g*32 +: 32]),
				.head_out(head),
				.tail_out(tail),
				.full_out(fifo_full[g]),
				.empty_out(fifo_empty[g])
			);
			assign fifo_status[g*16 +: 16] = {3'b000, fifo_full[g], 3'b000, fifo_empty[g],
				{(4-AW){1'b0}}, head, {(4-AW){1'b0}}, tail};
		end
	endgenerate

	// Status word registered so it shows the state after each access
	always @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			FIFO_STATUS_OUT <= {4{`ADCSQ_ST_RESET}};
		end else begin
			FIFO_STATUS_OUT <= fifo_status;
		end
	end

	// Pop port: lowest requesting sequencer wins; empty reads return zero
	always @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			FIFO_DATA_OUT <= 32'h00000000;
			FIFO_DATA_VALID_OUT <= 1'b0;
		end else begin
			FIFO_DATA_VALID_OUT <= |FIFO_READ_IN;
			if (FIFO_READ_IN[0]) begin
				FIFO_DATA_OUT <= fifo_empty[0] ? 32'h00000000 : fifo_data[31:0];
			end else if (FIFO_READ_IN[1]) begin
				FIFO_DATA_OUT <= fifo_empty[1] ? 32'h00000000 : fifo_data[63:32];
			end else if (FIFO_READ_IN[2]) begin
				FIFO_DATA_OUT <= fifo_empty[2] ? 32'h00000000 : fifo_data[95:64];
			end else if (FIFO_READ_IN[3]) begin
				FIFO_DATA_OUT <= fifo_empty[3] ? 32'h00000000 : fifo_data[127:96];
			end
		end
	end

	// Sticky flags: a set in the clearing cycle wins over the clear
	always @(posedge CLK_IN) begin
		if (SYS_RST_IN) begin
			raw_q <= 4'h0;
			ovf_q <= 4'h0;
			unf_q <= 4'h0;
		end else begin
			raw_q <= (raw_q & ~INT_CLEAR_IN) | int_set;
			ovf_q <= (ovf_q & ~OVF_CLEAR_IN) |
				({4{push_v_q}} & (4'h1 << push_sel_q) & ~fifo_in_ready);
			unf_q <= (unf_q & ~UNF_CLEAR_IN) | (FIFO_READ_IN & fifo_empty);
		end
	end

	assign RAW_INT_STATUS_OUT = raw_q;
	assign MASKED_INT_STATUS_OUT = raw_q & INT_MASK_IN;
	assign SEQ_INT_OUT = raw_q & INT_MASK_IN;
	assign OVF_STATUS_OUT = ovf_q;
	assign UNF_STATUS_OUT = unf_q;
endmodule // adcsq_top
`default_nettype wire

// ### testbench/adcsq_monitor.sv
// Checker on the sequencer top ports: interrupt views, flags, reads, starts.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module adcsq_monitor (
	input wire logic CLK_IN,
	input wire logic SYS_RST_IN,
	input wire logic [3:0] INT_MASK_IN,
	input wire logic [3:0] INT_CLEAR_IN,
	input wire logic [3:0] OVF_CLEAR_IN,
	input wire logic [3:0] FIFO_READ_IN,
	input wire logic CONV_DONE_IN,
	input wire logic CONV_START_OUT,
	input wire logic [3:0] CONV_INPUT_OUT,
	input wire logic [3:0] CONV_NEG_INPUT_OUT,
	input wire logic CONV_DIFF_OUT,
	input wire logic [3:0] RAW_INT_STATUS_OUT,
	input wire logic [3:0] MASKED_INT_STATUS_OUT,
	input wire logic [3:0] SEQ_INT_OUT,
	input wire logic [3:0] OVF_STATUS_OUT,
	input wire logic FIFO_DATA_VALID_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (SYS_RST_IN);
	sequence s_read;
		|FIFO_READ_IN;
	endsequence
	// Starts fall on ADC ticks, six clocks apart at least
	sequence s_quiet;
		!CONV_START_OUT [*5];
	endsequence
	a_int_line_mask: assert property (SEQ_INT_OUT == (RAW_INT_STATUS_OUT & INT_MASK_IN))
		else $error("interrupt line differs from raw and mask");
	a_masked_view: assert property (MASKED_INT_STATUS_OUT == (RAW_INT_STATUS_OUT & INT_MASK_IN))
		else $error("masked view differs from raw and mask");
	a_start_spacing: assert property (CONV_START_OUT |=> s_quiet)
		else $error("conversion starts too close");
	a_read_answer: assert property (s_read |=> FIFO_DATA_VALID_OUT)
		else $error("read without data valid");
	a_no_idle_data: assert property (!(|FIFO_READ_IN) |=> !FIFO_DATA_VALID_OUT)
		else $error("data valid without read");
	a_diff_pair: assert property (CONV_START_OUT && CONV_DIFF_OUT |->
		!CONV_INPUT_OUT[0] && CONV_NEG_INPUT_OUT == CONV_INPUT_OUT + 4'h1)
		else $error("differential pair wrong");
	a_clear_raw: assert property (!CONV_DONE_IN && !$past(CONV_DONE_IN) |=>
		(RAW_INT_STATUS_OUT & $past(INT_CLEAR_IN)) == 4'h0)
		else $error("raw interrupt not cleared");
	a_raw_sticky: assert property ((($past(RAW_INT_STATUS_OUT) & ~$past(INT_CLEAR_IN))
		& ~RAW_INT_STATUS_OUT) == 4'h0)
		else $error("raw interrupt dropped without clear");
	a_raw_cause: assert property ((RAW_INT_STATUS_OUT & ~$past(RAW_INT_STATUS_OUT)) != 4'h0 |->
		$past(CONV_DONE_IN) || $past(CONV_DONE_IN, 2))
		else $error("raw interrupt without conversion");
	a_ovf_sticky: assert property ((($past(OVF_STATUS_OUT) & ~$past(OVF_CLEAR_IN))
		& ~OVF_STATUS_OUT) == 4'h0)
		else $error("overflow dropped without clear");
endmodule // adcsq_monitor
bind adcsq_top adcsq_monitor i_mon (.CLK_IN, .SYS_RST_IN, .INT_MASK_IN, .INT_CLEAR_IN,
	.OVF_CLEAR_IN, .FIFO_READ_IN, .CONV_DONE_IN, .CONV_START_OUT, .CONV_INPUT_OUT,
	.CONV_NEG_INPUT_OUT, .CONV_DIFF_OUT, .RAW_INT_STATUS_OUT, .MASKED_INT_STATUS_OUT,
	.SEQ_INT_OUT, .OVF_STATUS_OUT, .FIFO_DATA_VALID_OUT);
`default_nettype wire

// ### testbench/adcsq_core_model.sv
// Converter core stand-in: one done pulse per start, random delay.
// Assumes starts come further apart than its longest answer.
`timescale 1ns/100ps
`default_nettype none
module adcsq_core_model (
	input wire logic clk_in,
	input wire logic start_in,
	input wire logic [3:0] input_in,
	input wire logic [9:0] base_in,
	output logic done_out,
	output logic [9:0] result_out
);
	initial begin
		done_out = 1'b0;
		result_out = 10'h155;
	end
	always @(posedge clk_in) begin
		if (start_in) begin
			repeat (1 + $urandom % 4) @(posedge clk_in);
			done_out <= 1'b1;
			result_out <= base_in + {6'h0, input_in};
			@(posedge clk_in);
			done_out <= 1'b0;
			// Stale result inverted so a late sample shows up
			result_out <= ~(base_in + {6'h0, input_in});
		end
	end
endmodule // adcsq_core_model
`default_nettype wire

// ### testbench/adcsq_top_tb_top.sv
// Self-checking bench for the sequencer control block.
// Assumes the core model answers every start; inputs change at falling edges.
`timescale 1ns/100ps
`default_nettype none
`include "adcsq_regs.vh"
module adcsq_top_tb_top;
	logic clk = 1'b0;
	logic rst, done, st, fval, busy, cdiff, ctemp;
	logic [1:0] md;
	int n0 = 0;
	logic [3:0] en, swi, ext, msk, iclr, oclr, uclr, frd, r, cin, cneg, raw, mis, sint, ovf, unf;
	logic [7:0] pri;
	logic [15:0] tsel;
	logic [127:0] smux, sctl;
	logic [2:0] avg;
	logic [9:0] res, base;
	logic [63:0] fst;
	logic [31:0] fdat;
	logic [31:0] q[$];
	logic [7:0] ins[$];
	int fails = 0;
	int num_checks = 0;
	int starts = 0;
	always #5 clk = ~clk;
	adcsq_top i_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .SEQ_ENABLE_IN(en), .SEQ_PRIORITY_IN(pri),
		.TRIG_EVENT_SELECT_IN(tsel), .SW_INITIATE_IN(swi), .EXT_TRIG_IN(ext),
		.STEP_INPUT_SELECT_IN(smux), .STEP_CONTROL_IN(sctl), .AVG_CONTROL_IN(avg),
		.INT_MASK_IN(msk), .INT_CLEAR_IN(iclr), .OVF_CLEAR_IN(oclr), .UNF_CLEAR_IN(uclr),
		.FIFO_READ_IN(frd), .CONV_DONE_IN(done), .CONV_RESULT_IN(res), .CONV_START_OUT(st),
		.CONV_INPUT_OUT(cin), .CONV_NEG_INPUT_OUT(cneg), .CONV_DIFF_OUT(cdiff),
		.CONV_TEMP_OUT(ctemp),
		.RAW_INT_STATUS_OUT(raw), .MASKED_INT_STATUS_OUT(mis), .SEQ_INT_OUT(sint),
		.OVF_STATUS_OUT(ovf), .UNF_STATUS_OUT(unf), .FIFO_STATUS_OUT(fst),
		.FIFO_DATA_OUT(fdat), .FIFO_DATA_VALID_OUT(fval), .BUSY_OUT(busy));
	adcsq_core_model i_core (.clk_in(clk), .start_in(st), .input_in(cin), .base_in(base),
		.done_out(done), .result_out(res));
	task automatic chk(input string nm, input logic [63:0] s, input logic [63:0] e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_of_test();
		if (fails == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	function automatic logic [31:0] exp_w(input logic [3:0] i);
		return {22'h0, base + {6'h0, i}};
	endfunction
	// Sampled at the rising edge, before the design's own updates land
	always @(posedge clk) begin
		if (st === 1'b1) begin
			starts++;
			ins.push_back({cneg, cin});
			md = {ctemp, cdiff};
		end
		if (fval === 1'b1)
			chk("fifo data", fdat, q.pop_front());
	end
	// Bounded wait for k more starts, and optionally for idle
	task automatic wt(input int k, input bit idle);
		int t;
		t = starts + k;
		repeat (600) begin
			@(negedge clk);
			if (starts >= t && !(idle && busy !== 1'b0)) begin
				repeat (3) @(negedge clk);
				return;
			end
		end
		fails++;
		end_of_test();
	endtask
	task automatic sw(input logic [3:0] v, input int k);
		swi = v;
		@(negedge clk);
		swi = 4'h0;
		wt(k, 1);
	endtask
	task automatic rd(input int n, input logic [31:0] e);
		q.push_back(e);
		frd[n] = 1'b1;
		@(negedge clk);
		frd = 4'h0;
		@(negedge clk);
	endtask
	task automatic w1c(input logic [3:0] i, input logic [3:0] o, input logic [3:0] u);
		iclr = i;
		oclr = o;
		uclr = u;
		@(negedge clk);
		{iclr, oclr, uclr} = 12'h0;
		@(negedge clk);
	endtask
	initial begin
		{rst, en, pri, tsel, swi, ext} = {1'b1, 4'hf, 8'he4, 16'h0, 8'h0};
		{smux, sctl, avg, msk, iclr, oclr, uclr, frd} = '0;
		void'($urandom(51));
		base = 10'($urandom % 512);
		r = 4'($urandom % 6);
		repeat (16) @(negedge clk);
		rst = 1'b0;
		chk("status", fst, {4{`ADCSQ_ST_RESET}});
		smux[99:96] = r;
		sctl[99:96] = 4'he;
		sw(4'h8, 1);
		chk("input", ins.pop_front(), {4'h0, r});
		chk("mode", md, 2'b10);
		chk("raw", raw, 4'h8);
		chk("line", sint, 4'h0);
		msk = 4'h8;
		@(negedge clk);
		chk("line", sint, 4'h8);
		chk("masked", mis, 4'h8);
		chk("full", fst[60], 1'b1);
		w1c(4'h8, 4'h0, 4'h0);
		chk("raw", raw, 4'h0);
		sw(4'h8, 1);
		chk("ovf", ovf, 4'h8);
		rd(3, exp_w(r));
		rd(3, 32'h0);
		chk("unf", unf, 4'h8);
		w1c(4'h0, 4'h8, 4'h8);
		chk("flags", {ovf, unf}, 8'h0);
		ins.delete();
		for (int k = 0; k < 5; k++)
			smux[k*4 +: 4] = 4'(k);
		sctl[19:16] = 4'h2;
		sw(4'h1, 5);
		chk("steps", ins.size(), 5);
		chk("status0", fst[15:0], 16'h0005);
		for (int k = 0; k < 5; k++)
			rd(0, exp_w(4'(k)));
		chk("status0", fst[15:0], 16'h0155);
		ins.delete();
		smux[35:32] = 4'h2;
		sctl[35:32] = 4'h3;
		sw(4'h2, 1);
		chk("pair", ins.pop_front(), 8'h54);
		chk("mode", md, 2'b01);
		rd(1, exp_w(4'h4));
		smux[35:32] = 4'h1;
		sctl[35:32] = 4'h2;
		smux[67:64] = 4'h2;
		sctl[67:64] = 4'h2;
		pri = 8'hc6;
		sw(4'h6, 2);
		chk("order", {ins[0], ins[1]}, 16'h0201);
		rd(1, exp_w(4'h1));
		rd(2, exp_w(4'h2));
		avg = 3'h2;
		for (int c = 1; c < 5; c++) begin
			ins.delete();
			tsel[11:8] = 4'(c);
			@(negedge clk);
			ext[c-1] = 1'b1;
			wt(4, 1);
			ext = 4'h0;
			chk("averaged", ins.size(), 4);
			rd(2, exp_w(4'h2));
		end
		tsel[11:8] = 4'hf;
		wt(2, 0);
		en = 4'hb;
		wt(0, 1);
		n0 = starts;
		repeat (40) @(negedge clk);
		chk("disabled", starts, n0);
		chk("unread", q.size(), 0);
		end_of_test();
	end
endmodule // adcsq_top_tb_top
`default_nettype wire
